// ---- design/three_wire_serial_io_pkg.sv ----
// constants shared by the three-wire serial channel
package three_wire_serial_io_pkg;

    // register addresses on the internal bus
    localparam logic [15:0] MODE_CTRL_ADDR    = 16'hff60;
    localparam logic [15:0] BUS_IF_CTRL_ADDR  = 16'hff61;
    localparam logic [15:0] SHIFT_REG_ADDR    = 16'hff62;

    // reset values and unmapped read value
    localparam logic [7:0]  MODE_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  BUS_IF_CTRL_RESET = 8'h00;
    localparam logic [7:0]  SHIFT_REG_RESET   = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    // mode register fields
    localparam int CH_ENABLE_POS    = 7;
    localparam int ADDR_CMP_POS     = 6;
    localparam int WAKEUP_POS       = 5;
    localparam int MODE_HI_POS      = 4;
    localparam int MODE_MID_POS     = 3;
    localparam int BIT_ORDER_POS    = 2;
    localparam int CLK_SEL_HI_POS   = 1;
    localparam int CLK_SEL_LO_POS   = 0;

    // bus-interface control fields
    localparam int CMD_TRIG_POS     = 1;
    localparam int REL_TRIG_POS     = 0;

    // frame length
    localparam int FRAME_BITS       = 8;
    localparam logic [3:0] LAST_BIT = 4'h7;

endpackage

// ---- design/three_wire_serial_io.sv ----
// three-wire clocked serial channel with mode and bus-interface control registers
`timescale 1ns/1ps
`default_nettype none

// Function
// - reset clears the mode register to zero, channel stopped.
// - channel enable bit stops the channel at 0, runs it at 1.
// - mode bit 6 is read-only; writes to it are ignored.
// - with wake-up control 0 every finished transfer raises the request.
// - both upper mode bits set selects two-wire or bus mode, not three-wire.
// - top mode bit clear selects three-wire mode regardless of next bit.
// - clock select: 0x external pin, 10 eight-bit timer, 11 timer clock select.
// - when only transmitting the serial input pin is free as a port.
// - reset clears the bus-interface control register to zero.
// - command trigger clears output latch, self-clears, held 0 when disabled.
// - release trigger sets output latch unless command trigger is also set, self-clears, held 0 when disabled.
// - data moves in 8-bit frames in step with the serial clock.
// - shifting on falling clock edge; output latch drives serial output.
// - serial input captured into the shift register on rising clock edge.
// - after eight bits shifting stops; the request flag is set only with wake-up control 0.
// - serial output is push-pull and always shows the output latch.
// - with internal clock the idle clock pin level follows the port latch.
// - mode bit 2 chooses MSB-first or LSB-first transfer.
// - bit order works by reversing bus reads and writes of the shift register.
// - write starts a frame only if enabled and clock idle or pin high.
// - enabling after the shift register write starts no transfer.
module three_wire_serial_io
    import three_wire_serial_io_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // internal register bus
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdData,
    // clock sources and port latch
    input  wire logic        timerOutTick,
    input  wire logic        timerClkTick,
    input  wire logic        clockPortLatch,
    input  wire logic        txOnly,
    // request flag
    input  wire logic        irqClear,
    output logic             transferIrqFlag,
    output logic             siPortFree,
    // serial pins
    input  wire logic        serialClockIn,
    output logic             serialClockOut,
    output logic             serialClockOe_n,
    input  wire logic        serialIn,
    output logic             serialOut
);
    import three_wire_serial_io_pkg::*;

    typedef struct packed {
        logic [7:0] modeReg;
        logic [7:0] busIfReg;
        logic [7:0] shiftReg;
        logic       soLatch;
        logic       busy;
        logic [3:0] bitCnt;
        logic       sckLvl;
        logic       sckOut;
        logic       sckOe_n;
        logic       sckSync1;
        logic       sckSync2;
        logic       sckPrev;
        logic       siSync1;
        logic       siSync2;
        logic       irqFlag;
        logic       siFree;
        logic [7:0] rdData;
    } state_type;

    state_type state_ff;
    state_type nxt_state;

    function automatic logic [7:0] bitReverse(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < FRAME_BITS; i++) begin
            r[i] = d[FRAME_BITS - 1 - i];
        end
        return r;
    endfunction

    logic       chEnable;
    logic       threeWire;
    logic       internalClk;
    logic       lsbFirst;
    logic       tick;
    logic       fallEdge;
    logic       riseEdge;
    logic       shiftWr;
    logic       startOk;

    always_comb begin
        chEnable    = state_ff.modeReg[CH_ENABLE_POS];
        threeWire   = !state_ff.modeReg[MODE_HI_POS];
        internalClk = state_ff.modeReg[CLK_SEL_HI_POS];
        lsbFirst    = state_ff.modeReg[BIT_ORDER_POS];
        // internal source: 10 timer output, 11 timer clock select
        tick        = state_ff.modeReg[CLK_SEL_LO_POS] ? timerClkTick : timerOutTick;
        shiftWr     = regWr && (regAddr == SHIFT_REG_ADDR);
        // external clock: pin must be high; internal: clock must be stopped
        startOk     = chEnable && threeWire && !state_ff.busy
                      && (internalClk || state_ff.sckSync2);
        if (internalClk) begin
            fallEdge = state_ff.busy && tick && state_ff.sckLvl;
            riseEdge = state_ff.busy && tick && !state_ff.sckLvl;
        end else begin
            fallEdge = state_ff.busy && state_ff.sckPrev && !state_ff.sckSync2;
            riseEdge = state_ff.busy && !state_ff.sckPrev && state_ff.sckSync2;
        end
    end

    always_comb begin
        nxt_state = state_ff;

        // pin synchronisers; first stage feeds only the second
        nxt_state.sckSync1 = serialClockIn;
        nxt_state.sckSync2 = state_ff.sckSync1;
        nxt_state.sckPrev  = state_ff.sckSync2;
        nxt_state.siSync1  = serialIn;
        nxt_state.siSync2  = state_ff.siSync1;

        // triggers live one cycle, then clear themselves
        nxt_state.busIfReg[CMD_TRIG_POS] = 1'b0;
        nxt_state.busIfReg[REL_TRIG_POS] = 1'b0;

        // register writes
        if (regWr && (regAddr == MODE_CTRL_ADDR)) begin
            nxt_state.modeReg = regWrData;
            nxt_state.modeReg[ADDR_CMP_POS] = 1'b0;
        end else if (regWr && (regAddr == BUS_IF_CTRL_ADDR)) begin
            nxt_state.busIfReg = regWrData;
            if (!chEnable) begin
                nxt_state.busIfReg[CMD_TRIG_POS] = 1'b0;
                nxt_state.busIfReg[REL_TRIG_POS] = 1'b0;
            end else if (regWrData[CMD_TRIG_POS]) begin
                nxt_state.soLatch = 1'b0;
            end else if (regWrData[REL_TRIG_POS]) begin
                nxt_state.soLatch = 1'b1;
            end
        end else if (shiftWr && !state_ff.busy) begin
            // stop mode keeps it as a plain register; order reversed on the bus
            nxt_state.shiftReg = lsbFirst ? bitReverse(regWrData) : regWrData;
            nxt_state.busy     = startOk;
            nxt_state.bitCnt   = 4'h0;
            nxt_state.sckLvl   = 1'b1;
        end

        // shifting: out on falling edge, in on rising edge
        if (fallEdge) begin
            nxt_state.soLatch  = state_ff.shiftReg[FRAME_BITS - 1];
            nxt_state.shiftReg = {state_ff.shiftReg[FRAME_BITS - 2:0], 1'b0};
            nxt_state.sckLvl   = 1'b0;
        end
        if (riseEdge) begin
            // transmit-only leaves the input pin to the port
            nxt_state.shiftReg[0] = txOnly ? 1'b0 : state_ff.siSync2;
            nxt_state.sckLvl      = 1'b1;
            nxt_state.bitCnt      = state_ff.bitCnt + 4'h1;
            if (state_ff.bitCnt == LAST_BIT) begin
                nxt_state.busy = 1'b0;
            end
        end

        // request flag: set wins over clear
        if (irqClear) begin
            nxt_state.irqFlag = 1'b0;
        end
        if (riseEdge && (state_ff.bitCnt == LAST_BIT) && !state_ff.modeReg[WAKEUP_POS]) begin
            nxt_state.irqFlag = 1'b1;
        end

        // stopped channel: no transfer, triggers cleared
        if (!chEnable) begin
            nxt_state.busy   = 1'b0;
            nxt_state.bitCnt = 4'h0;
            nxt_state.busIfReg[CMD_TRIG_POS] = 1'b0;
            nxt_state.busIfReg[REL_TRIG_POS] = 1'b0;
        end

        // clock pin: idle level follows the port latch when driving
        nxt_state.sckOe_n = !(chEnable && threeWire && internalClk);
        nxt_state.sckOut  = nxt_state.busy ? nxt_state.sckLvl : clockPortLatch;
        nxt_state.siFree  = !chEnable || !threeWire || txOnly;

        // reads
        if (regRd) begin
            if (regAddr == MODE_CTRL_ADDR) begin
                nxt_state.rdData = state_ff.modeReg;
            end else if (regAddr == BUS_IF_CTRL_ADDR) begin
                nxt_state.rdData = state_ff.busIfReg;
            end else if (regAddr == SHIFT_REG_ADDR) begin
                nxt_state.rdData = lsbFirst ? bitReverse(state_ff.shiftReg)
                                            : state_ff.shiftReg;
            end else begin
                nxt_state.rdData = READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff          <= '0;
            state_ff.modeReg  <= MODE_CTRL_RESET;
            state_ff.busIfReg <= BUS_IF_CTRL_RESET;
            state_ff.shiftReg <= SHIFT_REG_RESET;
            state_ff.sckLvl   <= 1'b1;
            // clock pin idles high; starting the synchroniser low would fake an edge
            state_ff.sckSync1 <= 1'b1;
            state_ff.sckSync2 <= 1'b1;
            state_ff.sckPrev  <= 1'b1;
            state_ff.sckOe_n  <= 1'b1;
            state_ff.siFree   <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign regRdData       = state_ff.rdData;
    assign transferIrqFlag = state_ff.irqFlag;
    assign siPortFree      = state_ff.siFree;
    assign serialClockOut  = state_ff.sckOut;
    assign serialClockOe_n = state_ff.sckOe_n;
    assign serialOut       = state_ff.soLatch;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_ADDR_CMP_ZERO: assert property (
        state_ff.modeReg[ADDR_CMP_POS] == 1'b0)
        else $error("mode bit 6 became set");

    AST_CMD_CLEARS: assert property (
        regWr && regAddr == BUS_IF_CTRL_ADDR && chEnable
        && regWrData[CMD_TRIG_POS] && !fallEdge |=> serialOut == 1'b0)
        else $error("command trigger did not clear output");

    AST_REL_SETS: assert property (
        regWr && regAddr == BUS_IF_CTRL_ADDR && chEnable && !regWrData[CMD_TRIG_POS]
        && regWrData[REL_TRIG_POS] && !fallEdge |=> serialOut == 1'b1)
        else $error("release trigger did not set output");

    AST_TRIG_HELD: assert property (
        !chEnable && !$past(state_ff.modeReg[CH_ENABLE_POS])
        |-> state_ff.busIfReg[1:0] == 2'b00)
        else $error("trigger bits set while disabled");

    AST_NO_START_OFF: assert property (
        shiftWr && !chEnable |=> !state_ff.busy)
        else $error("transfer started while disabled");

    AST_NO_START_2W: assert property (
        shiftWr && !state_ff.busy && !threeWire |=> !state_ff.busy)
        else $error("transfer started outside three-wire mode");

    AST_FRAME_START: assert property (
        $rose(state_ff.busy) |-> state_ff.bitCnt == 4'h0)
        else $error("frame started with nonzero count");

    AST_DONE_IRQ: assert property (
        $fell(state_ff.busy) && chEnable
        && !state_ff.modeReg[WAKEUP_POS] |-> transferIrqFlag)
        else $error("no request after frame");

    AST_EXT_NO_DRIVE: assert property (
        !internalClk |=> serialClockOe_n)
        else $error("clock driven with external source");

    AST_IDLE_LEVEL: assert property (
        !nxt_state.busy |=> serialClockOut == $past(clockPortLatch))
        else $error("idle clock level not from port latch");

    // the output latch moves only on a falling edge or a trigger write
    AST_SO_HOLD: assert property (
        !fallEdge && !(regWr && regAddr == BUS_IF_CTRL_ADDR)
        |=> $stable(serialOut))
        else $error("serial output moved without cause");

    AST_OFF_STOPS: assert property (
        !chEnable |=> !state_ff.busy)
        else $error("stopped channel still busy");

    AST_OFF_COUNT: assert property (
        !chEnable |=> state_ff.bitCnt == 4'h0)
        else $error("stopped channel kept a bit count");

    AST_IRQ_HOLD: assert property (
        transferIrqFlag && !irqClear |=> transferIrqFlag)
        else $error("request flag dropped without clear");

    AST_SI_FREE: assert property (
        txOnly |=> siPortFree)
        else $error("input pin not freed when transmitting only");

    AST_INT_DRIVES: assert property (
        chEnable && threeWire && internalClk |=> !serialClockOe_n)
        else $error("internal clock not driven on the pin");

    AST_CNT_RANGE: assert property (
        state_ff.bitCnt <= FRAME_BITS)
        else $error("bit count beyond frame length");

    AST_EIGHT_STOPS: assert property (
        riseEdge && state_ff.bitCnt == LAST_BIT |=> !state_ff.busy)
        else $error("shifting went on after eight bits");

    AST_BUSY_WR_KEEPS: assert property (
        shiftWr && state_ff.busy && !fallEdge && !riseEdge
        |=> state_ff.shiftReg == $past(state_ff.shiftReg))
        else $error("shift write accepted during a frame");

    AST_CMD_SELF_CLR: assert property (
        state_ff.busIfReg[CMD_TRIG_POS] && !(regWr && regAddr == BUS_IF_CTRL_ADDR)
        |=> !state_ff.busIfReg[CMD_TRIG_POS])
        else $error("command trigger did not clear itself");

    AST_REL_SELF_CLR: assert property (
        state_ff.busIfReg[REL_TRIG_POS] && !(regWr && regAddr == BUS_IF_CTRL_ADDR)
        |=> !state_ff.busIfReg[REL_TRIG_POS])
        else $error("release trigger did not clear itself");

    AST_FALL_OUT: assert property (
        fallEdge |=> serialOut == $past(state_ff.shiftReg[FRAME_BITS - 1]))
        else $error("falling edge did not present the top bit");

    AST_RISE_IN: assert property (
        riseEdge && !txOnly |=> state_ff.shiftReg[0] == $past(state_ff.siSync2))
        else $error("rising edge did not capture the input");

    AST_REL_HELD: assert property (
        !chEnable && !$past(chEnable) |-> !state_ff.busIfReg[REL_TRIG_POS])
        else $error("release trigger set while disabled");

    AST_IDLE_SHIFT: assert property (
        !state_ff.busy && !shiftWr |=> $stable(state_ff.shiftReg))
        else $error("shift register moved while stopped");

    AST_RD_ADDR_CMP: assert property (
        regRd && regAddr == MODE_CTRL_ADDR |=> !regRdData[ADDR_CMP_POS])
        else $error("mode read showed bit 6 set");

endmodule
`default_nettype wire

// ---- verification/serial_peer_model.sv ----
// far-side peripheral model: clocks external frames and shifts data both ways
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
    // control from the bench
    input  wire logic       startExt,
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    // serial wires
    input  wire logic       sck,
    input  wire logic       devOut,
    output logic            extClk,
    output logic            peerOut,
    output logic      [7:0] rxByte
);
    logic [7:0] sh = 8'h00;
    int         n = 0;
    initial begin
        extClk = 1'b1;
        peerOut = 1'b0;
        rxByte = 8'h00;
    end
    // the clock only runs inside a frame and rests high between frames
    always @(posedge startExt) begin
        repeat (8) begin
            #40 extClk = 1'b0;
            #40 extClk = 1'b1;
        end
    end
    always @(posedge load) begin
        sh = txByte;
        n = 0;
    end
    always @(negedge sck) begin
        peerOut = sh[7];
        sh = {sh[6:0], 1'b0};
    end
    // after the last bit the line is let go to a misleading level
    always @(posedge sck) begin
        rxByte = {rxByte[6:0], devOut};
        n++;
        if (n == 8) begin
            #20 peerOut = ~peerOut;
        end
    end
endmodule
`default_nettype wire

// ---- verification/three_wire_serial_io_tb.sv ----
// self-checking bench for the three-wire serial channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module three_wire_serial_io_tb;
    import three_wire_serial_io_pkg::*;
    logic        sys_clk, rst, regWr, regRd, timerOutTick, timerClkTick, txOnly;
    logic        irqClear, transferIrqFlag, siPortFree, serialClockOut, serialClockOe_n;
    logic        serialOut, extClk, peerOut, startExt, load;
    logic [15:0] regAddr;
    logic [7:0]  regWrData, regRdData, peerTx, peerRx;
    logic [7:0]  modes [6] = '{8'h80, 8'h82, 8'h83, 8'h85, 8'h8e, 8'h87};
    logic        clockPortLatch;
    logic [7:0]  expq [$];
    wire logic   sckWire = serialClockOe_n ? extClk : serialClockOut;
    int          error_cnt = 0;
    int          checked = 0;
    int          tcnt = 0;
    three_wire_serial_io dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .timerOutTick(timerOutTick), .timerClkTick(timerClkTick),
        .clockPortLatch(clockPortLatch), .txOnly(txOnly), .irqClear(irqClear),
        .transferIrqFlag(transferIrqFlag), .siPortFree(siPortFree),
        .serialClockIn(sckWire), .serialClockOut(serialClockOut),
        .serialClockOe_n(serialClockOe_n), .serialIn(peerOut), .serialOut(serialOut));
    serial_peer_model peer_u (.startExt(startExt), .load(load), .txByte(peerTx),
        .sck(sckWire), .devOut(serialOut), .extClk(extClk), .peerOut(peerOut),
        .rxByte(peerRx));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // timer sources at two unrelated rates
    always @(negedge sys_clk) begin
        tcnt++;
        timerOutTick <= (tcnt % 3 == 0);
        timerClkTick <= (tcnt % 5 == 0);
    end
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
    endfunction
    task automatic conclude();
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge sys_clk);
        regWr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge sys_clk);
        regRd = 1'b0;
        @(negedge sys_clk);
        `CHK(regRdData, e)
    endtask
    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_flag();
        int i;
        for (i = 0; i < 400 && transferIrqFlag !== 1'b1; i++) @(negedge sys_clk);
        if (i == 400) begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic frame(input logic [7:0] m, input logic [7:0] d, input logic [7:0] p);
        logic lsb;
        logic [7:0] ex;
        lsb = m[BIT_ORDER_POS];
        // model: peer sees the stored byte, the bus then reads back what the peer sent
        expq.push_back(lsb ? rev8(d) : d);
        expq.push_back(txOnly ? 8'h00 : (lsb ? rev8(p) : p));
        wr(MODE_CTRL_ADDR, m);
        peerTx = p;
        load = 1'b1;
        wr(SHIFT_REG_ADDR, d);
        load = 1'b0;
        `CHK(serialClockOe_n, ~m[CLK_SEL_HI_POS])
        startExt = ~m[CLK_SEL_HI_POS];
        wait_flag();
        startExt = 1'b0;
        `CHK(siPortFree, txOnly)
        ex = expq.pop_front();
        `CHK(peerRx, ex)
        ex = expq.pop_front();
        rd(SHIFT_REG_ADDR, ex);
        if (m[CLK_SEL_HI_POS]) `CHK(serialClockOut, clockPortLatch)
        @(negedge sys_clk);
        irqClear = 1'b1;
        @(negedge sys_clk);
        irqClear = 1'b0;
        `CHK(transferIrqFlag, 1'b0)
    endtask
    initial begin
        {rst, regWr, regRd, txOnly, irqClear, startExt, load} = 7'b1000000;
        {timerOutTick, timerClkTick, regAddr, regWrData, peerTx} = '0;
        clockPortLatch = 1'b1;
        void'($urandom(58771));
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        rd(MODE_CTRL_ADDR, MODE_CTRL_RESET);
        rd(BUS_IF_CTRL_ADDR, BUS_IF_CTRL_RESET);
        rd(16'hff70, READ_UNMAPPED);
        wr(BUS_IF_CTRL_ADDR, 8'h03);
        rd(BUS_IF_CTRL_ADDR, 8'h00);
        `CHK(serialOut, 1'b0)
        wr(MODE_CTRL_ADDR, 8'hff);
        rd(MODE_CTRL_ADDR, 8'hbf);
        wr(MODE_CTRL_ADDR, 8'h80);
        wr(BUS_IF_CTRL_ADDR, 8'h01);
        @(negedge sys_clk);
        `CHK(serialOut, 1'b1)
        rd(BUS_IF_CTRL_ADDR, 8'h00);
        wr(BUS_IF_CTRL_ADDR, 8'h03);
        @(negedge sys_clk);
        `CHK(serialOut, 1'b0)
        foreach (modes[k]) frame(modes[k], 8'($urandom), 8'($urandom));
        // idle clock level must follow the port latch low as well
        @(negedge sys_clk);
        clockPortLatch = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK(serialClockOut, 1'b0)
        clockPortLatch = 1'b1;
        txOnly = 1'b1;
        frame(8'h82, 8'($urandom), 8'($urandom));
        `CHK(siPortFree, 1'b1)
        txOnly = 1'b0;
        // upper mode bits both set: a shift write must not start a frame
        wr(MODE_CTRL_ADDR, 8'h9a);
        wr(SHIFT_REG_ADDR, 8'h5a);
        repeat (100) @(negedge sys_clk);
        `CHK(transferIrqFlag, 1'b0)
        wr(MODE_CTRL_ADDR, 8'h02);
        wr(SHIFT_REG_ADDR, 8'h55);
        wr(MODE_CTRL_ADDR, 8'h82);
        repeat (100) @(negedge sys_clk);
        `CHK(transferIrqFlag, 1'b0)
        rd(SHIFT_REG_ADDR, 8'h55);
        conclude();
    end
endmodule
`default_nettype wire
